// File: hw/oahr_core.sv
// extended attribute sets, auto character height and symmetric row spacing
// assumes writes arrive decoded from the serial receiver; sync pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module oahr_core
  import oahr_pkg::*;
#(
  parameter int LINE_W = 11
)(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire oahr_wr_t WR_REQ,
  input wire logic [3:0] RD_COL,
  output logic [15:0] RD_DATA,
  input wire logic HFLB,
  input wire logic VFLB,
  input wire logic EXTENDED_CODE_ENABLE,
  input wire logic AUTO_HEIGHT_ENABLE,
  input wire logic [5:0] MANUAL_CHAR_HEIGHT,
  input wire logic CHAR_CODE_SELECT_HI,
  input wire logic CHAR_CODE_SELECT_LO,
  input wire oahr_attr_t CHAR_ATTR_IN,
  output oahr_attr_t ATTR_OUT,
  output logic [5:0] CHAR_HEIGHT,
  output logic [4:0] ROW_PAD_TOP,
  output logic [4:0] ROW_PAD_BOTTOM,
  output logic [6:0] ROW_PITCH,
  output logic [LINE_W-1:0] LINES_PER_FRAME
);
  function automatic oahr_attr_t pick_set(input logic [15:0] sets, input logic [1:0] code);
    pick_set = oahr_attr_t'(sets[code*OAHR_SET_W +: OAHR_SET_W]);
  endfunction

  // pin synchronisers, third stage for edge detect
  logic [2:0] hs_reg, hs_next;
  logic [2:0] vs_reg, vs_next;
  logic h_edge, v_edge;

  always_comb
  begin
    hs_next = {hs_reg[1:0], HFLB};
    vs_next = {vs_reg[1:0], VFLB};
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      hs_reg <= 3'h0;
      vs_reg <= 3'h0;
    end
    else
    begin
      hs_reg <= hs_next;
      vs_reg <= vs_next;
    end
  end

  assign h_edge = hs_reg[1] & ~hs_reg[2];
  assign v_edge = vs_reg[1] & ~vs_reg[2];

  // pending registers written by the controller, active copies per frame
  logic [15:0] ext_pend_reg, ext_pend_next;
  logic [15:0] ar_pend_reg, ar_pend_next;
  logic [15:0] ext_act_reg, ext_act_next;
  logic [15:0] ar_act_reg, ar_act_next;
  logic [15:0] rd_reg, rd_next;

  always_comb
  begin
    ext_pend_next = ext_pend_reg;
    ar_pend_next = ar_pend_reg;
    ext_act_next = ext_act_reg;
    ar_act_next = ar_act_reg;
    if (WR_REQ.stb && WR_REQ.col == OAHR_COL_EXT_SETS)
      ext_pend_next = WR_REQ.data;
    // (R11) reserved bits dropped
    if (WR_REQ.stb && WR_REQ.col == OAHR_COL_AUTO_ROW)
      ar_pend_next = WR_REQ.data & OAHR_AUTO_ROW_MASK;
    // (R12) frame boundary commit
    if (v_edge)
    begin
      ext_act_next = ext_pend_reg;
      ar_act_next = ar_pend_reg;
    end
    unique case (RD_COL)
      OAHR_COL_EXT_SETS: rd_next = ext_pend_reg;
      OAHR_COL_AUTO_ROW: rd_next = ar_pend_reg;
      default: rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ext_pend_reg <= OAHR_EXT_SETS_RST;
      ar_pend_reg <= OAHR_AUTO_ROW_RST;
      ext_act_reg <= OAHR_EXT_SETS_RST;
      ar_act_reg <= OAHR_AUTO_ROW_RST;
      rd_reg <= 16'h0000;
    end
    else
    begin
      ext_pend_reg <= ext_pend_next;
      ar_pend_reg <= ar_pend_next;
      ext_act_reg <= ext_act_next;
      ar_act_reg <= ar_act_next;
      rd_reg <= rd_next;
    end
  end

  logic [5:0] auto_height_reference;
  logic [4:0] rs;
  assign auto_height_reference = ar_act_reg[OAHR_AUTO_HEIGHT_REFERENCE_LSB +: 6];
  assign rs = ar_act_reg[OAHR_RS_LSB +: 5];

  // attribute lookup
  logic [1:0] code_sel;
  oahr_attr_t attr_reg, attr_next;
  assign code_sel = {CHAR_CODE_SELECT_HI, CHAR_CODE_SELECT_LO};

  always_comb
  begin
    // (R1) (R2) set chosen by code
    if (EXTENDED_CODE_ENABLE)
      attr_next = pick_set(ext_act_reg, code_sel);
    else
      attr_next = CHAR_ATTR_IN;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      attr_reg <= '0;
    else
      attr_reg <= attr_next;
  end

  // line counting and height
  logic [LINE_W-1:0] lcnt_reg, lcnt_next;
  logic [LINE_W-1:0] lpf_reg, lpf_next;
  logic [5:0] hgt_reg, hgt_next;
  logic [6:0] pitch_reg, pitch_next;
  logic [LINE_W-1:0] quo;
  logic div_done, div_start, auto_on;

  assign auto_on = AUTO_HEIGHT_ENABLE && (auto_height_reference != 6'h00);
  assign div_start = v_edge && AUTO_HEIGHT_ENABLE && (ar_pend_reg[OAHR_AUTO_HEIGHT_REFERENCE_LSB +: 6] != 6'h00);

  oahr_div #(.DW(LINE_W)) u_div (
    .clk(CLK),
    .rst(SYS_RST),
    .start(div_start),
    .dividend(lcnt_reg),
    .divisor(ar_pend_reg[OAHR_AUTO_HEIGHT_REFERENCE_LSB +: 6]),
    .quotient(quo),
    .done(div_done)
  );

  always_comb
  begin
    lcnt_next = lcnt_reg;
    lpf_next = lpf_reg;
    hgt_next = hgt_reg;
    if (v_edge)
    begin
      lpf_next = lcnt_reg;
      lcnt_next = '0;
    end
    else if (h_edge && lcnt_reg != {LINE_W{1'b1}})
      lcnt_next = lcnt_reg + 1'b1;
    if (!auto_on)
    begin
      // (R7) manual height at frame start
      if (v_edge)
        hgt_next = MANUAL_CHAR_HEIGHT;
    end
    else if (div_done)
    begin
      // (R5) (R6) lines over reference, floor 18
      if (quo < LINE_W'(OAHR_MIN_HEIGHT))
        hgt_next = OAHR_MIN_HEIGHT;
      else if (quo > LINE_W'(OAHR_MAX_HEIGHT))
        hgt_next = OAHR_MAX_HEIGHT;
      else
        hgt_next = quo[5:0];
    end
    // (R9) (R10) pitch with rs on each side
    pitch_next = 7'(hgt_reg + OAHR_RS_SCALE * rs);
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      lcnt_reg <= '0;
      lpf_reg <= '0;
      hgt_reg <= OAHR_RST_HEIGHT;
      pitch_reg <= 7'(OAHR_RST_HEIGHT);
    end
    else
    begin
      lcnt_reg <= lcnt_next;
      lpf_reg <= lpf_next;
      hgt_reg <= hgt_next;
      pitch_reg <= pitch_next;
    end
  end

  assign RD_DATA = rd_reg;
  assign ATTR_OUT = attr_reg;
  assign CHAR_HEIGHT = hgt_reg;
  // (R8) (R9) equal pad both ends
  assign ROW_PAD_TOP = rs;
  assign ROW_PAD_BOTTOM = rs;
  assign ROW_PITCH = pitch_reg;
  assign LINES_PER_FRAME = lpf_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_ext_lookup: assert property (EXTENDED_CODE_ENABLE && code_sel == 2'b11 |=> ATTR_OUT == $past(ext_act_reg[15:12])) else $error("set 3 not applied"); // (R1)
  a_set_fields: assert property (EXTENDED_CODE_ENABLE && code_sel == 2'b00 |=> ATTR_OUT == $past(ext_act_reg[3:0])) else $error("set 0 field wrong"); // (R2)
  a_auto_height: assert property (auto_on && div_done && quo >= 18 && quo <= 63 ##1 auto_on |-> CHAR_HEIGHT == $past(quo[5:0])) else $error("auto height wrong"); // (R5)
  a_height_floor: assert property (auto_on && div_done && quo < 18 ##1 auto_on |-> CHAR_HEIGHT == 6'h12) else $error("height below floor"); // (R6)
  a_manual_height: assert property (!auto_on && v_edge |=> CHAR_HEIGHT == $past(MANUAL_CHAR_HEIGHT)) else $error("manual height not taken"); // (R7)
  a_rs_default: assert property ($rose(ROW_PAD_TOP != 5'h00) |-> $past(v_edge)) else $error("row space changed off frame"); // (R8)
  a_pitch_scale: assert property (##1 $stable(hgt_reg) && $stable(rs) |-> ROW_PITCH == 7'(hgt_reg + 2 * rs)) else $error("pitch not height plus twice space"); // (R10)
  a_pad_symm: assert property (##1 $stable(hgt_reg) && $stable(rs) |-> // (R9)
    ROW_PAD_TOP == ROW_PAD_BOTTOM &&
    ROW_PITCH == 7'(CHAR_HEIGHT) + 7'(ROW_PAD_TOP) + 7'(ROW_PAD_BOTTOM))
    else $error("row padding asymmetric");
  a_reserved_zero: assert property (RD_COL == OAHR_COL_AUTO_ROW |=> (RD_DATA & 16'hc0e0) == 16'h0000) else $error("reserved bits nonzero"); // (R11)
  a_frame_hold: assert property (!v_edge |=> $stable(ext_act_reg) && $stable(ar_act_reg)) else $error("settings changed mid frame"); // (R12)
endmodule
`default_nettype wire

// File: shared/oahr_pkg.sv
// constants and carrier types for the osd attribute, height and row-space block
// assumes a 16-bit internal register bus from the serial receiver, sync pins active high
// How it works
// (R1) with extended codes enabled, a character's two select bits pick one of four stored sets
// (R2) set 3 sits in bits 15-12, set 2 in 11-8, set 1 in 7-4 and set 0 in 3-0
// (R3) the controller programs the sets first and then picks one per character
// (R4) with auto height on, the controller loads the reference field, bits 13-8, with 1 to 63
// (R5) with auto height on and a reference set, height is lines per frame over the reference
// (R6) an auto height below 18 lines is raised to 18 lines
// (R7) with auto height off, height comes from the manual height field
// (R8) the row space field, bits 4-0, gives the blank lines on each side of a row and resets to zero
// (R9) spacing is split evenly by extending both the first and last scan line of a row
// (R10) total spacing lines between rows are the row space field times two
// (R11) reserved bits 15-14 and 7-5 of the height and spacing register ignore writes, read zero
// (R12) register changes take effect only at the next vertical frame boundary
package oahr_pkg;
  localparam logic [3:0] OAHR_COL_EXT_SETS = 4'h3;
  localparam logic [3:0] OAHR_COL_AUTO_ROW = 4'h4;
  localparam logic [15:0] OAHR_EXT_SETS_RST = 16'h0000;
  localparam logic [15:0] OAHR_AUTO_ROW_RST = 16'h0000;
  localparam logic [15:0] OAHR_AUTO_ROW_MASK = 16'h3f1f;
  localparam int OAHR_SET_W = 4;
  localparam int OAHR_AUTO_HEIGHT_REFERENCE_LSB = 8;
  localparam int OAHR_RS_LSB = 0;
  localparam logic [5:0] OAHR_MIN_HEIGHT = 6'h12;
  localparam logic [5:0] OAHR_MAX_HEIGHT = 6'h3f;
  localparam logic [5:0] OAHR_RST_HEIGHT = 6'h12;
  localparam int OAHR_RS_SCALE = 2;

  typedef struct packed {
    logic blink;
    logic shadow;
    logic raster_intensity;
    logic char_intensity;
  } oahr_attr_t;

  typedef struct packed {
    logic stb;
    logic [3:0] col;
    logic [15:0] data;
  } oahr_wr_t;
endpackage

// File: hw/oahr_div.sv
// serial restoring divider, one quotient bit per clock
// assumes start is a one-cycle pulse and divisor is nonzero
`timescale 1ns/1ps
`default_nettype none
module oahr_div
  import oahr_pkg::*;
#(
  parameter int DW = 11
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [DW-1:0] dividend,
  input wire logic [5:0] divisor,
  output logic [DW-1:0] quotient,
  output logic done
);
  typedef enum logic {OAHR_D_IDLE, OAHR_D_RUN} oahr_dstate_t;
  oahr_dstate_t st_reg, st_next;
  logic [DW-1:0] dvd_reg, dvd_next;
  logic [DW-1:0] quo_reg, quo_next;
  logic [5:0] rem_reg, rem_next;
  logic [5:0] dsr_reg, dsr_next;
  logic [$clog2(DW+1)-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic [6:0] rem_sh;

  always_comb
  begin
    st_next = st_reg;
    dvd_next = dvd_reg;
    quo_next = quo_reg;
    rem_next = rem_reg;
    dsr_next = dsr_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    rem_sh = {rem_reg, dvd_reg[DW-1]};
    unique case (st_reg)
      OAHR_D_IDLE:
      begin
        if (start)
        begin
          dvd_next = dividend;
          dsr_next = divisor;
          rem_next = 6'h00;
          quo_next = '0;
          cnt_next = ($clog2(DW+1))'(DW);
          st_next = OAHR_D_RUN;
        end
      end
      OAHR_D_RUN:
      begin
        dvd_next = {dvd_reg[DW-2:0], 1'b0};
        if (rem_sh >= {1'b0, dsr_reg})
        begin
          rem_next = 6'(rem_sh - {1'b0, dsr_reg});
          quo_next = {quo_reg[DW-2:0], 1'b1};
        end
        else
        begin
          rem_next = rem_sh[5:0];
          quo_next = {quo_reg[DW-2:0], 1'b0};
        end
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == 1)
        begin
          st_next = OAHR_D_IDLE;
          done_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= OAHR_D_IDLE;
      dvd_reg <= '0;
      quo_reg <= '0;
      rem_reg <= 6'h00;
      dsr_reg <= 6'h01;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      dvd_reg <= dvd_next;
      quo_reg <= quo_next;
      rem_reg <= rem_next;
      dsr_reg <= dsr_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign quotient = quo_reg;
  assign done = done_reg;
endmodule
`default_nettype wire

// File: tb/oahr_host.sv
// controller model: loads register words over the decoded write path
// assumes the block takes a write at the rising clock edge with stb high
`timescale 1ns/1ps
`default_nettype none
module oahr_host
  import oahr_pkg::*;
(
  input wire logic CLK,
  output oahr_wr_t WR_REQ
);
  initial WR_REQ = '0;

  task automatic write(input logic [3:0] col, input logic [15:0] data);
    @(posedge CLK);
    WR_REQ <= '{stb: 1'b1, col: col, data: data};
    @(posedge CLK);
    // released word shows the inverse, not the last value
    WR_REQ <= '{stb: 1'b0, col: ~col, data: ~data};
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// testbench: register loads, frame timing and attribute selection
// assumes the host model drives writes and this module drives the sync pins
`timescale 1ns/1ps
`default_nettype none
module tb
  import oahr_pkg::*;
;
  localparam logic [15:0] SETS = 16'ha5c3;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  oahr_wr_t wr_req;
  logic [3:0] rd_col = 4'h0;
  logic [15:0] rd_data;
  logic hflb = 1'b0;
  logic vflb = 1'b0;
  logic ext_en = 1'b0;
  logic auto_en = 1'b0;
  logic [5:0] man_h = 6'h14;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b0;
  oahr_attr_t attr_in = '0;
  oahr_attr_t attr_out;
  logic [5:0] char_h;
  logic [4:0] pad_top;
  logic [4:0] pad_bot;
  logic [6:0] pitch;
  logic [10:0] lines;
  int err_total = 0;
  int tests_run = 0;
  int tbl [4][4] = '{'{10, 1, 400, 40}, '{10, 1, 100, 18}, '{20, 1, 800, 40},
    '{1, 2, 100, 63}};

  always #4 clk = ~clk;

  oahr_host oahr_host_inst (.CLK(clk), .WR_REQ(wr_req));

  oahr_core oahr_core_inst (
    .CLK(clk), .SYS_RST(sys_rst), .WR_REQ(wr_req), .RD_COL(rd_col), .RD_DATA(rd_data),
    .HFLB(hflb), .VFLB(vflb), .EXTENDED_CODE_ENABLE(ext_en), .AUTO_HEIGHT_ENABLE(auto_en),
    .MANUAL_CHAR_HEIGHT(man_h), .CHAR_CODE_SELECT_HI(sel_hi), .CHAR_CODE_SELECT_LO(sel_lo),
    .CHAR_ATTR_IN(attr_in), .ATTR_OUT(attr_out), .CHAR_HEIGHT(char_h),
    .ROW_PAD_TOP(pad_top), .ROW_PAD_BOTTOM(pad_bot), .ROW_PITCH(pitch),
    .LINES_PER_FRAME(lines)
  );

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] col, input logic [15:0] exp);
    @(posedge clk);
    rd_col <= col;
    cyc(2);
    #1 chk("rd_data", rd_data, exp);
  endtask

  // n line pulses, then a frame boundary, then time for the height to settle
  task automatic frame(input int n);
    repeat (n)
    begin
      @(posedge clk);
      hflb <= 1'b1;
      cyc(4);
      hflb <= 1'b0;
      cyc(3);
    end
    vflb <= 1'b1;
    cyc(4);
    vflb <= 1'b0;
    cyc(24);
    #1;
  endtask

  task automatic geom(input logic [5:0] h, input logic [4:0] rs);
    chk("char_height", 16'(char_h), 16'(h));
    chk("pad_top", 16'(pad_top), 16'(rs));
    chk("pad_bottom", 16'(pad_bot), 16'(rs));
    chk("row_pitch", 16'(pitch), 16'(h) + 16'(OAHR_RS_SCALE) * 16'(rs));
  endtask

  initial
  begin
    #400us;
    err_total++;
    wrap_up();
  end

  initial
  begin
    cyc(12);
    sys_rst <= 1'b0;
    cyc(1);
    #1 geom(6'h12, 5'h00);
    rd(4'h3, 16'h0000);
    rd(4'h4, 16'h0000);
    oahr_host_inst.write(4'h4, 16'hffff);
    oahr_host_inst.write(4'h5, 16'hffff);
    rd(4'h4, 16'h3f1f);
    rd(4'h5, 16'h0000);
    oahr_host_inst.write(4'h4, 16'h0a03);
    oahr_host_inst.write(4'h3, SETS);
    rd(4'h3, SETS);
    chk("pad_top", 16'(pad_top), 16'h0000);
    frame(50);
    geom(6'h14, 5'h03);
    @(posedge clk);
    ext_en <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      {sel_hi, sel_lo} <= 2'(c);
      attr_in <= 4'h9;
      @(posedge clk);
      #1 chk("attr_out", 16'(attr_out), 16'(SETS[c*4 +: 4]));
    end
    @(posedge clk);
    ext_en <= 1'b0;
    cyc(2);
    #1 chk("attr_out", 16'(attr_out), 16'h0009);
    @(posedge clk);
    auto_en <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      oahr_host_inst.write(4'h4, 16'(tbl[i][0] * 256 + tbl[i][1]));
      #1 chk("char_height", 16'(char_h), i == 0 ? 16'h0014 : 16'(tbl[i-1][3]));
      frame(tbl[i][2]);
      chk("lines", 16'(lines), 16'(tbl[i][2]));
      geom(6'(tbl[i][3]), 5'(tbl[i][1]));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
